// [sim/mmp_seq_model.sv]
// sequencer and port channel model issuing memory cycles and privileged ops
`timescale 1ns/100ps
module mmp_seq_model (
    // clock
    input  wire logic        clk_in,
    // memory cycle request
    output logic        req_out, write_out, jump_out, port_out,
    output logic [14:0] addr_out,
    // privileged instruction request
    output logic        op_valid_out,
    output logic [2:0]  op_code_out,
    output logic [14:0] op_eff_out, op_ret_out,
    output logic [15:0] op_data_out
);
    initial begin
        {req_out, write_out, jump_out, port_out, op_valid_out} = 5'h00;
        {addr_out, op_eff_out, op_ret_out} = 45'h0;
        op_code_out = 3'h0;
        op_data_out = 16'h0000;
    end

    task mem(input logic [14:0] a, input logic w, j, p);
        @(posedge clk_in);
        req_out <= 1'b1;
        write_out <= w;
        jump_out <= j;
        port_out <= p;
        addr_out <= a;
        @(posedge clk_in);
        req_out <= 1'b0;
        addr_out <= ~a; // released lines must not keep the last address
    endtask

    task op(input logic [2:0] c, input logic [14:0] e, input logic [15:0] d);
        @(posedge clk_in);
        op_valid_out <= 1'b1;
        op_code_out <= c;
        op_eff_out <= e;
        op_ret_out <= e ^ 15'h5555;
        op_data_out <= d;
        @(posedge clk_in);
        op_valid_out <= 1'b0;
        op_eff_out <= ~e;
        op_data_out <= ~d;
    endtask
endmodule // mmp_seq_model

// [sim/mmp_unit_bench.sv]
// self-checking bench for the memory map protect unit
`timescale 1ns/100ps
module mmp_unit_bench;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        pm = 1'b0, iack = 1'b0, pf = 1'b0, skip_if_flag_set = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [7:0]  ra = 8'h00;
    logic [15:0] wd = 16'h0000;
    logic        mreq, mwr, mjmp, mport, opv, re, we, vl, pl, rs, ih, skip;
    logic [2:0]  opc;
    logic [14:0] la, eff, ret, pcv, rta, rtd, m;
    logic [15:0] opd, rdat;
    logic [19:0] phys;
    logic [9:0]  p0, p1, p3, o;
    logic        rd_d = 1'b0, mr_d = 1'b0, op_d = 1'b0, sk_d = 1'b0;
    logic [63:0] qr[$], qm[$], qo[$], qs[$];
    int          bad_count = 0;
    int          checks_done = 0;

    always #25 clk = ~clk;

    mmp_seq_model mmp_seq_model_inst (
        .clk_in(clk), .req_out(mreq), .write_out(mwr), .jump_out(mjmp), .port_out(mport), .addr_out(la),
        .op_valid_out(opv), .op_code_out(opc), .op_eff_out(eff), .op_ret_out(ret), .op_data_out(opd));

    mmp_unit mmp_unit_inst (
        .core_clk_in(clk), .rst_n_in(rst_n), .mem_req_in(mreq), .mem_write_in(mwr), .mem_jump_in(mjmp),
        .mem_port_in(mport), .mem_port_sel_in(1'b0), .log_addr_in(la), .protected_mode_in(pm),
        .expansion_bus_enable_in(1'b1), .int_ack_in(iack), .fetch_done_in(1'b0), .indirect3_in(1'b0),
        .power_fail_in(pf), .op_valid_in(opv), .op_code_in(opc), .op_eff_addr_in(eff), .op_return_in(ret),
        .op_data_in(opd), .sfs_test_in(skip_if_flag_set), .reg_addr_in(ra), .reg_wdata_in(wd), .reg_write_in(wr),
        .reg_read_in(rd), .phys_addr_out(phys), .mem_read_en_out(re), .mem_write_en_out(we),
        .violation_out(vl), .pc_load_out(pl), .pc_value_out(pcv), .ret_store_out(rs), .ret_addr_out(rta),
        .ret_data_out(rtd), .int_hold_out(ih), .skip_out(skip), .reg_rdata_out(rdat));

    task finish_test;
        $display("mismatches %0d comparisons %0d", bad_count, checks_done);
        if (bad_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // note layout: upper half is the mask of bits that count, lower half the value
    task chk(input logic [63:0] e, input logic [31:0] got);
        checks_done++;
        if ((got & e[63:32]) !== e[31:0]) begin
            bad_count++;
            $display("FAIL t=%0t got %h exp %h", $time, got & e[63:32], e[31:0]);
        end
    endtask

    task rdx(input logic [7:0] a, input logic [15:0] msk, ex);
        qr.push_back({16'h0000, msk, 16'h0000, ex});
        @(posedge clk);
        ra <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
    endtask

    task wrx(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        ra <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // refused cycles only compare enables and flag: the address is then meaningless
    task memx(input logic [14:0] a, input logic w, j, p, input logic [22:0] ex);
        qm.push_back({9'h000, ex[0] ? 23'h000007 : 23'h7FFFFF, 9'h000, ex});
        mmp_seq_model_inst.mem(a, w, j, p);
    endtask

    task opx(input logic [2:0] c, input logic [14:0] e, input logic [15:0] d, input logic [17:0] ex);
        qo.push_back({13'h0000, ex[15], ex[15] ? 18'h3FFFF : 18'h38000, 13'h0000, ex[15], ex});
        mmp_seq_model_inst.op(c, e, d);
    endtask

    task sfx(input logic ex);
        qs.push_back({32'h00000001, 31'h00000000, ex});
        @(posedge clk);
        skip_if_flag_set <= 1'b1;
        @(posedge clk);
        skip_if_flag_set <= 1'b0;
    endtask

    always @(posedge clk) begin
        {rd_d, mr_d, op_d, sk_d} <= {rd, mreq, opv, skip_if_flag_set};
    end

    always @(negedge clk) begin
        if (rd_d) chk(qr.pop_front(), {16'h0000, rdat});
        if (mr_d) chk(qm.pop_front(), {9'h000, phys, re, we, vl});
        if (op_d) chk(qo.pop_front(), {13'h0000, ih, vl, rs, pl, pcv});
        if (sk_d) chk(qs.pop_front(), {31'h00000000, skip});
    end

    initial begin
        #200000;
        bad_count++;
        finish_test;
    end

    initial begin
        p0 = 10'($urandom(33));
        p1 = 10'($urandom);
        p3 = 10'($urandom);
        o = 10'($urandom);
        m = 15'($urandom);
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rdx(8'h80, 16'hFFFF, 16'h0000);
        wrx(8'h21, {6'h00, p0});
        wrx(8'h20, {6'h00, p1});
        wrx(8'h23, {4'h0, 2'h2, p1});
        wrx(8'h24, {4'h0, 2'h1, p0});
        wrx(8'h43, {4'h0, 2'h2, p3});
        rdx(8'h23, 16'hFFFF, {4'h0, 2'h2, p1});
        wrx(8'h80, 16'hFFFF);
        rdx(8'h80, 16'hFFFF, 16'h0000);
        rdx(8'h90, 16'hFFFF, 16'h0000);
        opx(3'h3, 15'h1234, 16'hC000, {3'b001, 15'h1234});
        rdx(8'h80, 16'hFFFF, 16'h3000);
        memx({5'h01, o}, 1'b0, 1'b0, 1'b0, {p0, o, 3'b100});
        memx({5'h03, o}, 1'b0, 1'b0, 1'b0, 23'h000001);
        rdx(8'h81, 16'hFFFF, 16'h80E3);
        sfx(1'b1);
        @(posedge clk);
        iack <= 1'b1;
        @(posedge clk);
        iack <= 1'b0;
        sfx(1'b0);
        rdx(8'h80, 16'hFFFF, 16'hF000);
        memx({5'h04, o}, 1'b0, 1'b1, 1'b0, 23'h000001);
        rdx(8'h81, 16'hFFFF, 16'h40E4);
        memx({5'h04, o}, 1'b1, 1'b0, 1'b0, 23'h000001);
        memx({5'h03, o}, 1'b0, 1'b0, 1'b1, {p3, o, 3'b100});
        pm <= 1'b1;
        opx(3'h4, 15'h0000, 16'h05AB, 18'h20000);
        opx(3'h1, 15'h0100, 16'h0000, 18'h20000);
        rdx(8'h81, 16'h1000, 16'h1000);
        rdx(8'h80, 16'hFFFF, 16'hF800);
        pm <= 1'b0;
        opx(3'h4, 15'h0000, 16'h05AB, 18'h00000);
        rdx(8'h80, 16'hFFFF, 16'hF5AB);
        opx(3'h5, 15'h0000, 16'hFBCD, 18'h00000);
        rdx(8'h80, 16'hFFFF, 16'hF3CD);
        pm <= 1'b1;
        memx(15'h0010, 1'b1, 1'b0, 1'b0, 23'h000001);
        memx(15'h03D0, 1'b0, 1'b0, 1'b0, {p1, 10'h3D0, 3'b100});
        pm <= 1'b0;
        pf <= 1'b1;
        repeat (6) @(posedge clk);
        rdx(8'h80, 16'h1000, 16'h0000);
        pf <= 1'b0;
        repeat (4) @(posedge clk);
        rdx(8'h80, 16'h2000, 16'h0000);
        opx(3'h2, m, 16'h0000, {3'b011, m + 15'h0001});
        rdx(8'h80, 16'h2000, 16'h0000);
        opx(3'h1, ~m, 16'h0000, {3'b001, ~m});
        repeat (3) @(posedge clk);
        finish_test;
    end
endmodule // mmp_unit_bench

// [sim/mmp_unit_monitor.sv]
// assertion checker watching the memory map protect unit ports
`timescale 1ns/100ps
module mmp_unit_monitor (
    // clock, reset and requests
    input wire logic        core_clk_in, rst_n_in, mem_req_in, mem_write_in, mem_jump_in, mem_port_in,
    input wire logic        protected_mode_in, op_valid_in, sfs_test_in,
    input wire logic [14:0] log_addr_in, op_eff_addr_in,
    input wire logic [2:0]  op_code_in,
    // answers
    input wire logic        mem_read_en_out, mem_write_en_out, violation_out, pc_load_out,
    input wire logic        ret_store_out, skip_out,
    input wire logic [19:0] phys_addr_out,
    input wire logic [14:0] pc_value_out, ret_addr_out
);
    default clocking mon_cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    a_port_no_check: assert property (mem_req_in && mem_port_in |=> !violation_out)
        else $error("port cycle flagged");
    a_read_or_viol: assert property (mem_req_in && !mem_write_in && !mem_jump_in |=> mem_read_en_out != violation_out)
        else $error("read neither done nor refused");
    a_write_or_viol: assert property (mem_req_in && mem_write_in && !mem_jump_in |=> mem_write_en_out != violation_out)
        else $error("write neither done nor refused");
    a_jump_no_access: assert property (mem_req_in && mem_jump_in |=> !mem_read_en_out && !mem_write_en_out)
        else $error("jump check touched memory");
    a_page_offset: assert property (mem_req_in ##1 !violation_out |-> phys_addr_out[9:0] == $past(log_addr_in[9:0]))
        else $error("word offset altered");
    a_jsb_target: assert property (op_valid_in && op_code_in == 3'h2 && !protected_mode_in |=>
        pc_load_out && ret_store_out && pc_value_out == $past(op_eff_addr_in) + 15'h0001
        && ret_addr_out == $past(op_eff_addr_in)) else $error("subroutine jump target wrong");
    a_jump_target: assert property (op_valid_in && op_code_in == 3'h1 && !protected_mode_in |=>
        pc_load_out && pc_value_out == $past(op_eff_addr_in)) else $error("jump target wrong");
    a_priv_either: assert property (op_valid_in && protected_mode_in && op_code_in inside {3'h1, 3'h2, 3'h3} |=>
        pc_load_out != violation_out) else $error("privileged op neither run nor refused");
    a_skip_cause: assert property (!$past(sfs_test_in) |-> !skip_out)
        else $error("skip without test");
    a_viol_cause: assert property (violation_out |-> $past(mem_req_in || op_valid_in))
        else $error("violation without request");
endmodule // mmp_unit_monitor

bind mmp_unit mmp_unit_monitor mmp_unit_monitor_inst (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .mem_req_in(mem_req_in), .mem_write_in(mem_write_in),
    .mem_jump_in(mem_jump_in), .mem_port_in(mem_port_in), .protected_mode_in(protected_mode_in),
    .op_valid_in(op_valid_in), .sfs_test_in(sfs_test_in), .log_addr_in(log_addr_in),
    .op_eff_addr_in(op_eff_addr_in), .op_code_in(op_code_in), .mem_read_en_out(mem_read_en_out),
    .mem_write_en_out(mem_write_en_out), .violation_out(violation_out), .pc_load_out(pc_load_out),
    .ret_store_out(ret_store_out), .skip_out(skip_out), .phys_addr_out(phys_addr_out),
    .pc_value_out(pc_value_out), .ret_addr_out(ret_addr_out));

// [verilog/mmp_pkg.sv]
// package of constants and types for the memory map protect unit
package mmp_pkg;
    // ------------------------------------------------------------
    // widths and map organisation
    // ------------------------------------------------------------
    localparam int LOG_AW         = 15;
    localparam int PAGE_BITS      = 5;
    localparam int PHYS_PAGE_BITS = 10;
    localparam int PHYS_AW        = 20;
    localparam int MAP_REGS       = 32;
    localparam int NUM_MAPS       = 4;
    localparam int MAP_WORD_W     = 12;
    // ------------------------------------------------------------
    // map register fields
    // ------------------------------------------------------------
    localparam int MAPF_READ_PROT  = 11;
    localparam int MAPF_WRITE_PROT = 10;
    // ------------------------------------------------------------
    // status register fields
    // ------------------------------------------------------------
    localparam int STF_EN_LAST    = 15;
    localparam int STF_USER_LAST  = 14;
    localparam int STF_EN_NOW     = 13;
    localparam int STF_USER_NOW   = 12;
    localparam int STF_PROT_NOW   = 11;
    localparam int STF_FENCE_SIDE = 10;
    // ------------------------------------------------------------
    // violation register fields
    // ------------------------------------------------------------
    localparam int VF_READ  = 15;
    localparam int VF_WRITE = 14;
    localparam int VF_BASE  = 13;
    localparam int VF_PRIV  = 12;
    localparam int VF_XBUS  = 7;
    localparam int VF_EN    = 6;
    localparam int VF_USER  = 5;
    // ------------------------------------------------------------
    // fence layout and base page limit
    // ------------------------------------------------------------
    localparam int          FENCE_W     = 11;
    localparam logic [14:0] BASE_PAGE_TOP = 15'h0400; // octal 2000
    // ------------------------------------------------------------
    // register port addresses (chosen)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS    = 8'h80;
    localparam logic [7:0] ADDR_VIOLATION = 8'h81;
    // map words occupy 8'h00..8'h7F: map index in bits 6:5, entry in 4:0
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [1:0]  RST_MAP  = 2'h0;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ          = 20_000_000;
    localparam int PWR_FAIL_US     = 500;
    localparam int PWR_FAIL_CYCLES = (PWR_FAIL_US * (CLK_HZ / 1_000_000));
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MMP_MAP_SYSTEM,
        MMP_MAP_USER,
        MMP_MAP_PORT_A,
        MMP_MAP_PORT_B
    } mmp_map_t;
    typedef enum logic [2:0] {
        MMP_OP_NONE,
        MMP_OP_JUMP_DIS,
        MMP_OP_JSB_DIS,
        MMP_OP_RESTORE,
        MMP_OP_LOAD_FA,
        MMP_OP_LOAD_FB
    } mmp_op_t;
endpackage

// [verilog/mmp_unit.sv]
// memory map protect unit: translation, protection and privileged map control
`timescale 1ns/100ps
// Summary of operation
// - upper 5 logical address bits replaced by 10-bit page from selected map
// - map word holds read protect bit 11, write protect bit 10, page
// - status bits 15..11: last enable, last map, enable, map, protected mode
// - status bits 9..0 fence address, bit 10 selects mapped side of fence
// - violation register captures cause flags and enable, map, page on violation
// - read of read-protected page is blocked and flags read violation
// - write to write-protected page leaves memory unchanged, flags write violation
// - jump into write-protected page is suppressed as write violation
// - port channel accesses skip all checks and never violate
// - read or write violation signals memory protect logic, interrupt code 05
// - flag-set skip on code 05 skips only when this unit violated
// - four maps reachable as one contiguous register block
// - base page fence check applies with system or user map
// - power failure forces system map, at least 500 us to run
// - on power return every map is disabled and invalid
// - jump-and-disable loads effective address into pc, then disables unit
// - subroutine variant stores return at m, pc becomes m+1, then disables
// - after disabling jumps or restore, interrupts held until next fetch, unless indirect3_in is set
// - privileged jumps and restore in protected mode violate unless unit enabled with system map
// - restore takes status word bits 15, 14 only: enable and map
// - load fence from a copies a bits 10..0 into fence
// - load fence from b copies b bits 10..0 into fence
// - fence load in protected mode violates and keeps fence, unless unit enabled with system map
module mmp_unit #(
    parameter int NUM_MAPS = mmp_pkg::NUM_MAPS
) (
    // clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        rst_n_in,
    // memory cycle request from the sequencer or port channels
    input  wire logic        mem_req_in,
    input  wire logic        mem_write_in,
    input  wire logic        mem_jump_in,
    input  wire logic        mem_port_in,
    input  wire logic        mem_port_sel_in,
    input  wire logic [14:0] log_addr_in,
    // processor mode
    input  wire logic        protected_mode_in,
    input  wire logic        expansion_bus_enable_in,
    input  wire logic        int_ack_in,
    input  wire logic        fetch_done_in,
    input  wire logic        indirect3_in,
    input  wire logic        power_fail_in,
    // privileged instruction request
    input  wire logic        op_valid_in,
    input  wire logic [2:0]  op_code_in,
    input  wire logic [14:0] op_eff_addr_in,
    input  wire logic [14:0] op_return_in,
    input  wire logic [15:0] op_data_in,
    // skip test on select code 05
    input  wire logic        sfs_test_in,
    // register port
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [15:0] reg_wdata_in,
    input  wire logic        reg_write_in,
    input  wire logic        reg_read_in,
    // memory cycle answer
    output logic [19:0] phys_addr_out,
    output logic        mem_read_en_out,
    output logic        mem_write_en_out,
    output logic        violation_out,
    // privileged instruction answer
    output logic        pc_load_out,
    output logic [14:0] pc_value_out,
    output logic        ret_store_out,
    output logic [14:0] ret_addr_out,
    output logic [14:0] ret_data_out,
    output logic        int_hold_out,
    output logic        skip_out,
    // register port answer
    output logic [15:0] reg_rdata_out
);
    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    if (NUM_MAPS != mmp_pkg::NUM_MAPS) begin : g_bad_maps
        $error("map count must be four");
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] pf_sync_reg;
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            pf_sync_reg <= 3'h0;
        end else begin
            pf_sync_reg <= {pf_sync_reg[1:0], power_fail_in};
        end
    end
    logic pf_now;
    assign pf_now = pf_sync_reg[1];

    // third stage only delays the settled pin: power return is its falling edge
    logic pf_return;
    assign pf_return = pf_sync_reg[2] && !pf_now;

    // ------------------------------------------------------------
    // map storage
    // ------------------------------------------------------------
    logic [11:0] map_reg [NUM_MAPS*mmp_pkg::MAP_REGS];
    logic        maps_valid_reg;
    logic        en_reg;
    logic        user_reg;
    logic        en_last_reg;
    logic        user_last_reg;
    logic [10:0] fence_reg;
    logic [15:0] viol_reg;
    logic        mmp_caused_reg;

    // map word addresses sit below the status and violation pair
    function automatic logic is_map_addr(input logic [7:0] a);
        is_map_addr = !a[7];
    endfunction

    // map writes through the contiguous block
    always_ff @(posedge core_clk_in) begin
        if (reg_write_in && is_map_addr(reg_addr_in)) begin
            map_reg[reg_addr_in[6:0]] <= reg_wdata_in[11:0];
        end
    end

    // ------------------------------------------------------------
    // translation and protection
    // ------------------------------------------------------------
    function automatic logic [6:0] map_index(input logic [1:0] m, input logic [4:0] p);
        map_index = {m, p};
    endfunction

    logic [1:0]  cur_map;
    logic [11:0] entry;
    logic        in_base;
    logic        fence_hit;
    logic        rd_viol;
    logic        wr_viol;
    logic        base_viol;
    logic        checking;
    always_comb begin
        if (mem_port_in) begin
            cur_map = mem_port_sel_in ? 2'(mmp_pkg::MMP_MAP_PORT_B) : 2'(mmp_pkg::MMP_MAP_PORT_A);
        end else begin
            cur_map = user_reg ? 2'(mmp_pkg::MMP_MAP_USER) : 2'(mmp_pkg::MMP_MAP_SYSTEM);
        end
        entry     = map_reg[map_index(cur_map, log_addr_in[14:10])];
        in_base   = (log_addr_in < mmp_pkg::BASE_PAGE_TOP);
        // fence side 0: fence..2000 mapped; side 1: below fence mapped
        if (fence_reg[mmp_pkg::STF_FENCE_SIDE]) begin
            fence_hit = in_base && (log_addr_in[9:0] < fence_reg[9:0]);
        end else begin
            fence_hit = in_base && (log_addr_in[9:0] >= fence_reg[9:0]);
        end
        checking  = mem_req_in && en_reg && !mem_port_in;
        rd_viol   = checking && !mem_write_in && !mem_jump_in && entry[mmp_pkg::MAPF_READ_PROT];
        wr_viol   = checking && (mem_write_in || mem_jump_in)
                    && entry[mmp_pkg::MAPF_WRITE_PROT];
        // fence applies to system and user maps; a base page write into the
        // unmapped portion from protected mode counts as a base page violation
        base_viol = checking && protected_mode_in && mem_write_in && !in_base ? 1'b0
                    : (checking && protected_mode_in && mem_write_in && !fence_hit && in_base);
    end

    logic mapped_here;
    assign mapped_here = en_reg && (mem_port_in || !in_base || fence_hit);

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            phys_addr_out    <= 20'h00000;
            mem_read_en_out  <= 1'b0;
            mem_write_en_out <= 1'b0;
        end else begin
            if (mapped_here) begin
                phys_addr_out <= {entry[9:0], log_addr_in[9:0]};
            end else begin
                phys_addr_out <= {5'h00, log_addr_in};
            end
            mem_read_en_out  <= mem_req_in && !mem_write_in && !mem_jump_in && !rd_viol;
            mem_write_en_out <= mem_req_in && mem_write_in && !wr_viol && !base_viol;
        end
    end

    // ------------------------------------------------------------
    // privileged instructions
    // ------------------------------------------------------------
    logic priv_op;
    logic priv_ok;
    logic priv_viol;
    assign priv_op   = op_valid_in && (op_code_in != 3'(mmp_pkg::MMP_OP_NONE));
    assign priv_ok   = !protected_mode_in || (en_reg && !user_reg);
    assign priv_viol = priv_op && !priv_ok;

    logic any_viol;
    assign any_viol = rd_viol || wr_viol || base_viol || priv_viol;

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            pc_load_out   <= 1'b0;
            pc_value_out  <= 15'h0000;
            ret_store_out <= 1'b0;
            ret_addr_out  <= 15'h0000;
            ret_data_out  <= 15'h0000;
        end else begin
            pc_load_out   <= 1'b0;
            ret_store_out <= 1'b0;
            if (priv_op && priv_ok) begin
                unique case (mmp_pkg::mmp_op_t'(op_code_in))
                    mmp_pkg::MMP_OP_JUMP_DIS: begin
                        pc_load_out  <= 1'b1;
                        pc_value_out <= op_eff_addr_in;
                    end
                    mmp_pkg::MMP_OP_JSB_DIS: begin
                        ret_store_out <= 1'b1;
                        ret_addr_out  <= op_eff_addr_in;
                        ret_data_out  <= op_return_in;
                        pc_load_out   <= 1'b1;
                        pc_value_out  <= op_eff_addr_in + 15'h0001;
                    end
                    mmp_pkg::MMP_OP_RESTORE: begin
                        pc_load_out  <= 1'b1;
                        pc_value_out <= op_eff_addr_in;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // unit enable, map selection, fence
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            en_reg         <= 1'b0;
            user_reg       <= 1'b0;
            maps_valid_reg <= 1'b0;
            fence_reg      <= 11'h000;
        end else if (pf_now) begin
            user_reg <= 1'b0;
        end else if (pf_return) begin
            // map contents did not survive the outage: distrust them until rewritten
            en_reg         <= 1'b0;
            maps_valid_reg <= 1'b0;
        end else begin
            if (reg_write_in && is_map_addr(reg_addr_in)) begin
                maps_valid_reg <= 1'b1;
            end
            if (priv_op && priv_ok) begin
                unique case (mmp_pkg::mmp_op_t'(op_code_in))
                    mmp_pkg::MMP_OP_JUMP_DIS,
                    mmp_pkg::MMP_OP_JSB_DIS: begin
                        en_reg <= 1'b0;
                    end
                    mmp_pkg::MMP_OP_RESTORE: begin
                        en_reg   <= op_data_in[15] && maps_valid_reg;
                        user_reg <= op_data_in[14];
                    end
                    mmp_pkg::MMP_OP_LOAD_FA: begin
                        fence_reg <= op_data_in[10:0];
                    end
                    mmp_pkg::MMP_OP_LOAD_FB: begin
                        fence_reg <= op_data_in[10:0];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // interrupt snapshot of enable and map
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            en_last_reg   <= 1'b0;
            user_last_reg <= 1'b0;
        end else if (int_ack_in) begin
            en_last_reg   <= en_reg;
            user_last_reg <= user_reg;
        end
    end

    // interrupt hold after disabling jumps and restore
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            int_hold_out <= 1'b0;
        end else if (priv_op && priv_ok && !indirect3_in
                     && (op_code_in == 3'(mmp_pkg::MMP_OP_JUMP_DIS)
                      || op_code_in == 3'(mmp_pkg::MMP_OP_JSB_DIS)
                      || op_code_in == 3'(mmp_pkg::MMP_OP_RESTORE))) begin
            int_hold_out <= 1'b1;
        end else if (fetch_done_in) begin
            int_hold_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // violation capture and reporting
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            viol_reg       <= mmp_pkg::RST_WORD;
            mmp_caused_reg <= 1'b0;
            violation_out  <= 1'b0;
        end else begin
            violation_out <= any_viol;
            if (any_viol) begin
                viol_reg <= {rd_viol, wr_viol, base_viol, priv_viol, 4'h0,
                             expansion_bus_enable_in, en_reg, user_reg, log_addr_in[14:10]};
                mmp_caused_reg <= 1'b1;
            end else if (int_ack_in) begin
                mmp_caused_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // register port and skip
    // ------------------------------------------------------------
    logic [15:0] status_word;
    assign status_word = {en_last_reg, user_last_reg, en_reg, user_reg, protected_mode_in, fence_reg};

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= mmp_pkg::RST_WORD;
            skip_out      <= 1'b0;
        end else begin
            skip_out <= sfs_test_in && mmp_caused_reg;
            if (!reg_read_in) begin
                reg_rdata_out <= mmp_pkg::RST_WORD;
            end else if (reg_addr_in == mmp_pkg::ADDR_STATUS) begin
                reg_rdata_out <= status_word;
            end else if (reg_addr_in == mmp_pkg::ADDR_VIOLATION) begin
                reg_rdata_out <= viol_reg;
            end else if (is_map_addr(reg_addr_in)) begin
                reg_rdata_out <= {4'h0, map_reg[reg_addr_in[6:0]]};
            end else begin
                reg_rdata_out <= mmp_pkg::RST_WORD;
            end
        end
    end
endmodule // mmp_unit
